// >>> core/ttl_pkg.sv
// Package for the two-input trigger logic unit: operation codes, source selects, timing constants.
// Assumes one 125 MHz system clock and an asynchronous active-low reset.
package ttl_pkg;

    // Boolean operation selection
    typedef enum logic [2:0] {
        TTL_OP_AND,
        TTL_OP_NAND,
        TTL_OP_OR,
        TTL_OP_NOR,
        TTL_OP_XOR,
        TTL_OP_XNOR
    } ttl_op_t;

    localparam int unsigned CLK_PERIOD_NS    = 8;
    localparam int unsigned DEBOUNCE_TIME_NS = 1000;
    localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NUM_LINES        = 4;
    localparam int unsigned SEL_W            = 2;
    localparam int unsigned CNT_W            = 20;

    localparam logic RESULT_RESET = 1'b0;

endpackage : ttl_pkg

// >>> core/ttl_debounce.sv
// Debouncer for one conditioned input line.
// Assumes the input is synchronous to clock_in; output follows a level stable for the set count.
module ttl_debounce #(
    parameter int unsigned CNT_W = ttl_pkg::CNT_W
) (
    input  wire logic             clock_in,     // System clock
    input  wire logic             nrst_in,      // Async reset, active low
    input  wire logic             enable_in,    // Debouncer placed on this line
    input  wire logic [CNT_W-1:0] duration_in,  // Stable cycles needed
    input  wire logic             raw_in,       // Conditioned line level
    output logic                  clean_out     // Debounced level
);

    typedef struct packed {
        logic             level;
        logic [CNT_W-1:0] count;
    } ttl_deb_state_t;

    ttl_deb_state_t state_q;
    ttl_deb_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (!enable_in) begin
            state_d.level = raw_in;
            state_d.count = '0;
        end else if (raw_in == state_q.level) begin
            state_d.count = '0;
        end else if (state_q.count + 1'b1 >= duration_in) begin
            // Level held long enough: accept it
            state_d.level = raw_in;
            state_d.count = '0;
        end else begin
            state_d.count = state_q.count + 1'b1;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // Without a debouncer the line passes straight through, so it costs no extra cycle
    assign clean_out = enable_in ? state_q.level : raw_in;

endmodule // ttl_debounce

// >>> core/ttl_logic.sv
// Two-operand trigger logic stage with optional per-line debouncing and result routing.
// Assumes conditioned inputs synchronous to clock_in; selects are static configuration inputs.

// Summary of operation
// - The operation is chosen among AND, NAND, OR, NOR, XOR and XNOR.
// - The result follows the standard truth table of the chosen operation for all four operand pairs.
// - The first operand comes from the selected first source and the second from the selected second source.
// - In trigger-enable mode the trigger enable input becomes the second operand.
// - The result can be routed out as the camera trigger source.
// - The result is offered as an operand for a further chained stage.
// - The result can be routed to a digital output line.
// - A debouncer placed on a line cleans that line before it reaches the logic.
module ttl_logic #(
    parameter int unsigned NUM_LINES = ttl_pkg::NUM_LINES,
    parameter int unsigned SEL_W     = ttl_pkg::SEL_W,
    parameter int unsigned CNT_W     = ttl_pkg::CNT_W
) (
    input  wire logic                 clock_in,                 // System clock, 125 MHz
    input  wire logic                 nrst_in,                  // Async reset, active low
    input  wire logic [NUM_LINES-1:0] line_in,                  // Conditioned input lines
    input  wire logic                 chain_in,                 // Result of a preceding stage
    input  wire logic                 trigger_enable_in,        // Trigger enable signal
    input  wire logic [SEL_W:0]       first_operand_source_in,  // Line index, or chain when top bit set
    input  wire logic [SEL_W:0]       second_operand_source_in, // Line index, or chain when top bit set
    input  wire logic                 trig_enable_mode_in,      // Use trigger enable as second operand
    input  wire ttl_pkg::ttl_op_t     op_sel_in,                // Boolean operation
    input  wire logic [NUM_LINES-1:0] debounce_en_in,           // Debouncer placed per line
    input  wire logic [CNT_W-1:0]     debounce_cycles_in,       // Debounce duration in cycles
    input  wire logic                 route_trigger_in,         // Drive result to trigger
    input  wire logic                 route_line_out_in,        // Drive result to output line
    output logic                      result_out,               // Registered result, chain source
    output logic                      trigger_out,              // Camera trigger source
    output logic                      line_out,                 // Digital output line
    output logic                      first_operand_value_out,  // Current first operand
    output logic                      second_operand_value_out  // Current second operand
);

    typedef struct packed {
        logic result;
        logic trigger;
        logic line;
        logic first_val;
        logic second_val;
    } ttl_state_t;

    ttl_state_t state_q;
    ttl_state_t state_d;

    logic [NUM_LINES-1:0] clean_lines;
    logic                 first_operand_value;
    logic                 second_operand_value;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_deb
            ttl_debounce #(
                .CNT_W       (CNT_W)
            ) u_deb (
                .clock_in    (clock_in),
                .nrst_in     (nrst_in),
                .enable_in   (debounce_en_in[gi]),
                .duration_in (debounce_cycles_in),
                .raw_in      (line_in[gi]),
                .clean_out   (clean_lines[gi])
            );
        end
    endgenerate

    // Picks a line, debounced where enabled, or the chained result
    function automatic logic pick_source(input logic [SEL_W:0] sel, input logic [NUM_LINES-1:0] lines,
                                         input logic chain);
        if (sel[SEL_W]) begin
            pick_source = chain;
        end else begin
            pick_source = lines[sel[SEL_W-1:0]];
        end
    endfunction

    function automatic logic apply_op(input ttl_pkg::ttl_op_t op, input logic a, input logic b);
        case (op)
            ttl_pkg::TTL_OP_AND:  apply_op = a & b;
            ttl_pkg::TTL_OP_NAND: apply_op = ~(a & b);
            ttl_pkg::TTL_OP_OR:   apply_op = a | b;
            ttl_pkg::TTL_OP_NOR:  apply_op = ~(a | b);
            ttl_pkg::TTL_OP_XOR:  apply_op = a ^ b;
            ttl_pkg::TTL_OP_XNOR: apply_op = ~(a ^ b);
            default:              apply_op = ttl_pkg::RESULT_RESET;
        endcase
    endfunction

    always_comb begin
        first_operand_value  = pick_source(first_operand_source_in, clean_lines, chain_in);
        second_operand_value = trig_enable_mode_in ? trigger_enable_in
                             : pick_source(second_operand_source_in, clean_lines, chain_in);
        state_d            = state_q;
        state_d.first_val  = first_operand_value;
        state_d.second_val = second_operand_value;
        state_d.result     = apply_op(op_sel_in, first_operand_value, second_operand_value);
        state_d.trigger    = route_trigger_in & state_d.result;
        state_d.line       = route_line_out_in & state_d.result;
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign result_out               = state_q.result;
    assign trigger_out              = state_q.trigger;
    assign line_out                 = state_q.line;
    assign first_operand_value_out  = state_q.first_val;
    assign second_operand_value_out = state_q.second_val;

endmodule // ttl_logic

// >>> verification/ttl_logic_sva.sv
// Checker for ttl_logic: truth table, operand sources, routing, reset.
// Bound to every ttl_logic; sees only its ports.
module ttl_logic_sva #(parameter int unsigned NUM_LINES = ttl_pkg::NUM_LINES) (
    input wire logic clock_in, nrst_in, chain_in, trigger_enable_in, trig_enable_mode_in, route_trigger_in,
    route_line_out_in, result_out, trigger_out, line_out, first_operand_value_out, second_operand_value_out,
    input wire logic [NUM_LINES-1:0] line_in, debounce_en_in, input wire logic [2:0] first_operand_source_in,
    second_operand_source_in, input wire ttl_pkg::ttl_op_t op_sel_in);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0][3:0] TT = {4'h9, 4'h6, 4'h1, 4'he, 4'h7, 4'h8};
    wire logic [2:0] s1 = first_operand_source_in, s2 = second_operand_source_in;
    wire logic v1 = first_operand_value_out, v2 = second_operand_value_out, m = trig_enable_mode_in;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    property p_truth; $past(nrst_in) |-> result_out == ($past(op_sel_in) < 3'h6 && TT[$past(op_sel_in)][{v1, v2}]); endproperty
    a_truth: assert property (p_truth) else $error("truth");
    property p_first; !s1[2] && !debounce_en_in[s1[1:0]] |=> v1 == $past(line_in[s1[1:0]]); endproperty
    a_first: assert property (p_first) else $error("first");
    property p_chain; s1[2] |=> v1 == $past(chain_in); endproperty
    a_chain: assert property (p_chain) else $error("chain");
    property p_second; !m && !s2[2] && !debounce_en_in[s2[1:0]] |=> v2 == $past(line_in[s2[1:0]]); endproperty
    a_second: assert property (p_second) else $error("second");
    property p_tenable; m |=> v2 == $past(trigger_enable_in); endproperty
    a_tenable: assert property (p_tenable) else $error("enable");
    property p_trig; trigger_out == (result_out && $past(route_trigger_in)); endproperty
    a_trig: assert property (p_trig) else $error("trigger");
    property p_line; line_out == (result_out && $past(route_line_out_in)); endproperty
    a_line: assert property (p_line) else $error("line");
    property p_rst; $rose(nrst_in) |-> !result_out && !v1 && !v2; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule // ttl_logic_sva
bind ttl_logic ttl_logic_sva #(.NUM_LINES(NUM_LINES)) ttl_logic_sva_i (.*);

// >>> verification/ttl_src_model.sv
// Source of the conditioned lines; line 0 may chatter.
// Levels change only on the falling clock edge.
module ttl_src_model (input wire logic clock_in, bounce_in, input wire logic [3:0] target_in, output logic [3:0] lines_out);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'h0;
    always @(negedge clock_in) tog <= ~tog;
    assign lines_out = target_in ^ {3'h0, bounce_in & tog};
endmodule // ttl_src_model

// >>> verification/tb_top.sv
// Bench for ttl_logic: operations, sources, routing, debounce.
// Inputs move on the falling edge.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'h0, nrst_in = 1'h0, chain_in = 1'h0, trigger_enable_in = 1'h0, trig_enable_mode_in = 1'h0;
    logic route_trigger_in = 1'h0, route_line_out_in = 1'h0, bnc = 1'h0, result_out, trigger_out, line_out;
    logic first_operand_value_out, second_operand_value_out;
    logic [3:0] line_in, tgt = 4'h0, debounce_en_in = 4'h1;
    logic [2:0] first_operand_source_in = 3'h0, second_operand_source_in = 3'h3;
    logic [19:0] debounce_cycles_in = 20'h8;
    logic [5:0][3:0] tt = {4'h9, 4'h6, 4'h1, 4'he, 4'h7, 4'h8};
    ttl_pkg::ttl_op_t op_sel_in = ttl_pkg::TTL_OP_OR;
    int errors = 0, samples_checked = 0;
    ttl_src_model ttl_src_model_i (.clock_in, .target_in(tgt), .bounce_in(bnc), .lines_out(line_in));
    ttl_logic ttl_logic_i (.*);
    initial forever #4 clock_in = ~clock_in;
    task automatic chk(string n, logic e, logic g);
        samples_checked++;
        errors += int'(g !== e);
        if (g !== e) $display("mismatch %s exp %b got %b", n, e, g);
    endtask
    task automatic stop_test;
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic t_deb;
        bnc = 1'h1;
        repeat (9) @(negedge clock_in);
        chk("glitch", 1'h0, result_out);
        {bnc, tgt} = {1'h0, 4'h1};
        repeat (11) @(negedge clock_in);
        chk("settled", 1'h1, result_out);
    endtask
    task automatic t_ops(logic alt);
        {debounce_en_in, second_operand_source_in, first_operand_source_in, trig_enable_mode_in} = {7'h1, alt, 2'h0, alt};
        for (int o = 0; o < 6; o++)
            for (int c = 0; c < 4; c++) begin
                op_sel_in = ttl_pkg::ttl_op_t'(o);
                {chain_in, trigger_enable_in, route_trigger_in, route_line_out_in, tgt} = {{2{c[1:0]}}, 2'h0, c[0] ^ alt, c[1] ^ alt};
                @(negedge clock_in);
                chk("result", tt[o][c], result_out);
                chk("trigger", tt[o][c] & c[1], trigger_out);
                chk("line", tt[o][c] & c[0], line_out);
                chk("first", c[1], first_operand_value_out);
                chk("second", c[0], second_operand_value_out);
            end
    endtask
    initial begin
        #160ns nrst_in = 1'h1;
        t_deb();
        t_ops(1'h0);
        t_ops(1'h1);
        stop_test();
    end
    initial #20us begin
        errors++;
        stop_test();
    end
endmodule // tb_top
